// ### hw/qdl_load_logic.sv
`timescale 1ns/10ps
`include "qdl_defs.svh"
module qdl_load_logic import qdl_pkg::*; #(
   parameter qdl_variant_t VARIANT = QDL_SERIAL, // port flavour
   parameter int NUM_CH = `QDL_NUM_CH, // channels
   parameter int DATA_W = `QDL_DATA_W // bits per channel
) (
   input wire logic mclk_i, // system clock
   input wire logic reset_n_i, // async reset
   input wire logic sclk_i, // serial shift clock
   input wire logic serial_sel_n_i, // serial select
   input wire logic serial_data_in_i, // serial data
   input wire logic serial_data_float_i, // pad sees data pin floating
   input wire logic write_strobe_n_i, // parallel write strobe
   input wire logic chan_sel_hi_i, // parallel address high
   input wire logic chan_sel_lo_i, // parallel address low
   input wire logic [7:0] parallel_data_bus_i, // parallel data
   input wire logic dac_load_strobe_n_i, // DAC load strobe
   input wire logic clear_n_i, // clear input and DAC registers; shutdown bits and shift register kept
   output qdl_bank_t input_value_o, // input registers
   output qdl_bank_t dac_value_o, // DAC registers
   output logic [3:0] chan_power_down_o, // per-channel shutdown
   output logic hw_power_down_o // hardware shutdown
);

   generate
      if (NUM_CH != `QDL_NUM_CH || DATA_W != `QDL_DATA_W) begin : g_bad_geom
         $error("qdl_load_logic: two address bits and 8-bit fields only");
      end
   endgenerate

   localparam qdl_core_t CORE_RST = '{
      s1: `QDL_PINS_IDLE,
      s2: `QDL_PINS_IDLE,
      s3: `QDL_PINS_IDLE,
      in_reg: `QDL_RST_BANK,
      dac_reg: `QDL_RST_BANK,
      pd_all: 1'b0,
      pd_ch: `QDL_PD_NONE,
      pd_out: `QDL_PD_NONE
   };

   localparam logic IS_SER = (VARIANT == QDL_SERIAL);

   function automatic logic [3:0] chan_hit(input logic [1:0] chan);
      logic [3:0] hit;
      hit = 4'h0;
      hit[chan] = 1'b1;
      return hit;
   endfunction

   qdl_core_t core_q;
   qdl_core_t core_d;
   qdl_link_t link_q;
   qdl_link_t link_d;
   qdl_pins_t pins_w;
   qdl_word_t word_w;
   logic ser_acc;
   logic wr_rise;
   logic dac_load_strobe_n_rise;
   logic [3:0] ser_hit;
   logic [3:0] par_hit;

   // ------------------------------------------------------------
   // serial clock domain: the shift register only
   // ------------------------------------------------------------
   always_comb begin
      link_d = link_q;
      if (!serial_sel_n_i) begin
         link_d.shift_reg = {link_q.shift_reg[`QDL_WORD_BITS-2:0],
                             serial_data_in_i};
      end
   end

   // clear is not wired here, so a clear leaves a half word intact
   always_ff @(posedge sclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_q <= `QDL_RST_WORD;
      end else begin
         link_q <= link_d;
      end
   end

   // ------------------------------------------------------------
   // system clock domain
   // ------------------------------------------------------------
   assign pins_w = '{
      wr_n: write_strobe_n_i,
      dac_load_strobe_n_n: dac_load_strobe_n_i,
      clr_n: clear_n_i,
      sel_n: serial_sel_n_i,
      sclk: sclk_i,
      flt: serial_data_float_i,
      addr: {chan_sel_hi_i, chan_sel_lo_i},
      db: parallel_data_bus_i
   };

   // word is read only after select has stood high two mclk cycles,
   // so the shift register is frozen while it crosses
   assign word_w = link_q.shift_reg;

   assign ser_acc = IS_SER && core_q.s2.sel_n && !core_q.s3.sel_n
                    && !core_q.s2.sclk;
   assign wr_rise = core_q.s2.wr_n && !core_q.s3.wr_n;
   assign dac_load_strobe_n_rise = core_q.s2.dac_load_strobe_n_n && !core_q.s3.dac_load_strobe_n_n;
   assign ser_hit = ser_acc ? chan_hit({word_w.chan_sel_hi, word_w.chan_sel_lo})
                            : 4'h0;
   assign par_hit = (!IS_SER && !core_q.s2.wr_n) ? chan_hit(core_q.s2.addr)
                                                 : 4'h0;

   always_comb begin
      core_d = core_q;
      // first stage feeds only the second
      core_d.s1 = pins_w;
      core_d.s2 = core_q.s1;
      core_d.s3 = core_q.s2;

      for (int i = 0; i < 4; i++) begin
         if (ser_hit[i]) begin
            core_d.in_reg[i] = word_w.serial_data_field;
         end
         // input follows the bus while write is low; stops at its rise
         if (par_hit[i]) begin
            core_d.in_reg[i] = core_q.s2.db;
         end
      end

      // load strobe level only; select plays no part here
      for (int i = 0; i < 4; i++) begin
         if (!core_q.s2.dac_load_strobe_n_n) begin
            core_d.dac_reg[i] = core_d.in_reg[i];
         end
      end
      // with the strobe high the DAC registers keep their value,
      // which is also what its rising edge leaves latched

      if (ser_acc) begin
         core_d.pd_all = !word_w.power_down_all_n;
         if (ser_hit != 4'h0) begin
            for (int i = 0; i < 4; i++) begin
               if (ser_hit[i]) begin
                  core_d.pd_ch[i] = !word_w.power_down_selected_n;
               end
            end
         end
      end
      core_d.pd_out = core_d.pd_ch | {4{core_d.pd_all}};

      // clear wins over any write in the same cycle, held while low
      if (!core_q.s2.clr_n) begin
         core_d.in_reg = `QDL_RST_BANK;
         core_d.dac_reg = `QDL_RST_BANK;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         core_q <= CORE_RST;
      end else begin
         core_q <= core_d;
      end
   end

   assign input_value_o = core_q.in_reg;
   assign dac_value_o = core_q.dac_reg;
   assign chan_power_down_o = core_q.pd_out;
   // shutdown output only; register contents are untouched by it
   assign hw_power_down_o = core_q.s2.flt;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // byte lanes of the accepted word, for the one-register check
   logic [31:0] ser_mask;
   assign ser_mask = {{8{ser_hit[3]}}, {8{ser_hit[2]}},
                      {8{ser_hit[1]}}, {8{ser_hit[0]}}};

   property p_shift_adv;
      @(posedge sclk_i) disable iff (!reset_n_i)
      !serial_sel_n_i |=>
         link_q.shift_reg == {$past(link_q.shift_reg[10:0]),
                              $past(serial_data_in_i)};
   endproperty
   a_shift_adv: assert property (p_shift_adv)
      else $error("shift register did not advance by one bit");

   property p_shift_hold;
      @(posedge sclk_i) disable iff (!reset_n_i)
      serial_sel_n_i |=> $stable(link_q.shift_reg);
   endproperty
   a_shift_hold: assert property (p_shift_hold)
      else $error("shift register moved while deselected");

   property p_ser_load;
      @(posedge mclk_i) disable iff (!reset_n_i)
      ser_acc && core_q.s2.clr_n |=>
         input_value_o[$past({word_w.chan_sel_hi, word_w.chan_sel_lo})]
         == $past(word_w.serial_data_field);
   endproperty
   a_ser_load: assert property (p_ser_load)
      else $error("accepted serial data not in addressed input register");

   property p_pd_all;
      @(posedge mclk_i) disable iff (!reset_n_i)
      ser_acc && !word_w.power_down_all_n |=> chan_power_down_o == 4'hF;
   endproperty
   a_pd_all: assert property (p_pd_all)
      else $error("shutdown-all word left a channel powered");

   property p_pd_sel;
      @(posedge mclk_i) disable iff (!reset_n_i)
      ser_acc && word_w.power_down_all_n && !word_w.power_down_selected_n
      |=> chan_power_down_o[$past({word_w.chan_sel_hi, word_w.chan_sel_lo})];
   endproperty
   a_pd_sel: assert property (p_pd_sel)
      else $error("decoded shutdown missed the addressed channel");

   property p_clr_zero;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !core_q.s2.clr_n |=> (input_value_o == `QDL_RST_BANK)
                           && (dac_value_o == `QDL_RST_BANK);
   endproperty
   a_clr_zero: assert property (p_clr_zero)
      else $error("registers not zero while clear is low");

   property p_clr_sync;
      @(posedge mclk_i) disable iff (!reset_n_i)
      $fell(clear_n_i) ##1 !clear_n_i[*2] |=> dac_value_o == `QDL_RST_BANK;
   endproperty
   a_clr_sync: assert property (p_clr_sync)
      else $error("clear pin low three cycles yet DAC not zero");

   property p_dac_load_strobe_n_follow;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !core_q.s2.dac_load_strobe_n_n && core_q.s2.clr_n |=> dac_value_o == input_value_o;
   endproperty
   a_dac_load_strobe_n_follow: assert property (p_dac_load_strobe_n_follow)
      else $error("DAC registers not transparent under load strobe");

   property p_dac_load_strobe_n_hold;
      @(posedge mclk_i) disable iff (!reset_n_i)
      core_q.s2.dac_load_strobe_n_n && core_q.s2.clr_n |=> $stable(dac_value_o);
   endproperty
   a_dac_load_strobe_n_hold: assert property (p_dac_load_strobe_n_hold)
      else $error("DAC registers changed with load strobe high");

   property p_dac_load_strobe_n_latch;
      @(posedge mclk_i) disable iff (!reset_n_i)
      dac_load_strobe_n_rise && core_q.s2.clr_n ##1 core_q.s2.dac_load_strobe_n_n && core_q.s2.clr_n
      |=> dac_value_o == $past(dac_value_o, 2);
   endproperty
   a_dac_load_strobe_n_latch: assert property (p_dac_load_strobe_n_latch)
      else $error("DAC registers drifted after load strobe rise");

   property p_par_write;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !IS_SER && !core_q.s2.wr_n && core_q.s2.clr_n |=>
         input_value_o[$past(core_q.s2.addr)] == $past(core_q.s2.db);
   endproperty
   a_par_write: assert property (p_par_write)
      else $error("addressed input register not following data bus");

   property p_par_latch;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !IS_SER && core_q.s2.wr_n && !wr_rise && core_q.s2.clr_n |=>
         $stable(input_value_o);
   endproperty
   a_par_latch: assert property (p_par_latch)
      else $error("input registers changed with write strobe high");

   property p_par_pass;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !IS_SER && !core_q.s2.wr_n && !core_q.s2.dac_load_strobe_n_n && core_q.s2.clr_n
      |=> dac_value_o[$past(core_q.s2.addr)] == $past(core_q.s2.db);
   endproperty
   a_par_pass: assert property (p_par_pass)
      else $error("data bus did not pass through to DAC register");

   property p_hw_pd;
      @(posedge mclk_i) disable iff (!reset_n_i)
      hw_power_down_o == $past(serial_data_float_i, 2);
   endproperty
   a_hw_pd: assert property (p_hw_pd)
      else $error("hardware shutdown not two cycles behind its pin");

   property p_no_pin_shortcut;
      @(posedge mclk_i) disable iff (!reset_n_i)
      $changed(dac_load_strobe_n_i) && core_q.s1.dac_load_strobe_n_n == core_q.s2.dac_load_strobe_n_n
      |=> $stable(dac_value_o) || !core_q.s3.dac_load_strobe_n_n;
   endproperty
   a_no_pin_shortcut: assert property (p_no_pin_shortcut)
      else $error("DAC registers moved before the strobe was synchronised");

   property p_in_quiet;
      @(posedge mclk_i) disable iff (!reset_n_i)
      IS_SER && !ser_acc && core_q.s2.clr_n |=> $stable(input_value_o);
   endproperty
   a_in_quiet: assert property (p_in_quiet)
      else $error("input register moved without an accepted word");

   property p_ser_one;
      @(posedge mclk_i) disable iff (!reset_n_i)
      ser_acc && core_q.s2.clr_n |=>
         (input_value_o & ~$past(ser_mask)) == ($past(input_value_o) & ~$past(ser_mask));
   endproperty
   a_ser_one: assert property (p_ser_one)
      else $error("accepted word touched a register it did not address");

   property p_pd_keep;
      @(posedge mclk_i) disable iff (!reset_n_i)
      !ser_acc |=> $stable(chan_power_down_o);
   endproperty
   a_pd_keep: assert property (p_pd_keep)
      else $error("shutdown bits moved without an accepted word");

   c_ser_word: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      ser_acc && core_q.s2.clr_n);
   c_par_write: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      !IS_SER && wr_rise);
   c_dac_load_strobe_n_pulse: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      dac_load_strobe_n_rise);
   c_clear: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      $fell(core_q.s2.clr_n));
   c_pd_all: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      ser_acc && !word_w.power_down_all_n);

endmodule

// ### include/qdl_defs.svh
`ifndef QDL_DEFS_SVH
`define QDL_DEFS_SVH

// geometry of the load logic
`define QDL_NUM_CH 4
`define QDL_DATA_W 8
`define QDL_WORD_BITS 12

// serial word field positions
`define QDL_B_PD_ALL 11
`define QDL_B_PD_SEL 10
`define QDL_B_CHAN_HI 9
`define QDL_B_CHAN_LO 8

// reset and clear values
`define QDL_RST_BYTE 8'h00
`define QDL_RST_BANK 32'h0000_0000
`define QDL_RST_WORD 12'h000
`define QDL_PD_NONE 4'h0
`define QDL_PD_ALL 4'hF

// pin sampler idle: strobes high, shift clock low, no float
`define QDL_PINS_IDLE 16'hF000

// synchroniser depth seen by logic, in mclk cycles
`define QDL_SYNC_LAT 2

`endif

// ### include/qdl_pkg.sv
package qdl_pkg;

   typedef enum logic [0:0] {
      QDL_SERIAL = 1'b0,
      QDL_PARALLEL = 1'b1
   } qdl_variant_t;

   typedef logic [7:0] qdl_byte_t;
   typedef qdl_byte_t [3:0] qdl_bank_t;

   // 12-bit serial command word, msb first on the wire
   typedef struct packed {
      logic power_down_all_n;
      logic power_down_selected_n;
      logic chan_sel_hi;
      logic chan_sel_lo;
      qdl_byte_t serial_data_field;
   } qdl_word_t;

   // one sample of every asynchronous control and data pin except reset and serial data
   typedef struct packed {
      logic wr_n;
      logic dac_load_strobe_n_n;
      logic clr_n;
      logic sel_n;
      logic sclk;
      logic flt;
      logic [1:0] addr;
      qdl_byte_t db;
   } qdl_pins_t;

   // all state of the mclk domain
   typedef struct packed {
      qdl_pins_t s1;
      qdl_pins_t s2;
      qdl_pins_t s3;
      qdl_bank_t in_reg;
      qdl_bank_t dac_reg;
      logic pd_all;
      logic [3:0] pd_ch;
      logic [3:0] pd_out;
   } qdl_core_t;

   // all state of the serial clock domain
   typedef struct packed {
      qdl_word_t shift_reg;
   } qdl_link_t;

endpackage

// ### sim/qdl_host_model.sv
`timescale 1ns/10ps
module qdl_host_model (
   output logic sclk_o, // shift clock, low between frames except while idle_clocks runs
   output logic sel_n_o, // serial select
   output logic sdi_o // serial data
);
   initial begin
      sclk_o = 1'b0;
      sel_n_o = 1'b1;
      sdi_o = 1'b1;
   end
   // n bits from bit 11 down; n of 0 only pulses select
   task automatic send(input logic [11:0] w, input int n);
      #13;
      sel_n_o = 1'b0;
      for (int i = 11; i > 11 - n; i--) begin
         sdi_o = w[i];
         #20 sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
         #20;
      end
      #20 sel_n_o = 1'b1;
      // released line must not keep its last bit
      sdi_o = ~sdi_o;
      #60;
   endtask
   // clocks with select high; the shift register must ignore them
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         sdi_o = ~sdi_o;
         #20 sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
         #20;
      end
   endtask
endmodule

// ### sim/qdl_load_logic_tb.sv
`timescale 1ns/10ps
module qdl_load_logic_tb;
   import qdl_pkg::*;
   logic mclk, reset_n, flt, wr_n, a_hi, a_lo, ld_n, clr_n;
   logic [7:0] db;
   wire sclk, sel_n, serial_data_in;
   qdl_bank_t s_in, s_dac, p_in, p_dac, exp_in, snap;
   logic [3:0] s_pd, p_pd;
   logic s_hw, p_hw;
   int mismatches, checks, cycles;
   localparam qdl_bank_t PAT = 32'h80FF_5A01;

   qdl_host_model i_qdl_host_model (.sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(serial_data_in));
   qdl_load_logic #(.VARIANT(QDL_SERIAL)) i_qdl_load_logic (
      .mclk_i(mclk), .reset_n_i(reset_n), .sclk_i(sclk), .serial_sel_n_i(sel_n),
      .serial_data_in_i(serial_data_in), .serial_data_float_i(flt), .write_strobe_n_i(wr_n),
      .chan_sel_hi_i(a_hi), .chan_sel_lo_i(a_lo), .parallel_data_bus_i(db),
      .dac_load_strobe_n_i(ld_n), .clear_n_i(clr_n), .input_value_o(s_in),
      .dac_value_o(s_dac), .chan_power_down_o(s_pd), .hw_power_down_o(s_hw));
   qdl_load_logic #(.VARIANT(QDL_PARALLEL)) i_qdl_load_logic_par (
      .mclk_i(mclk), .reset_n_i(reset_n), .sclk_i(sclk), .serial_sel_n_i(sel_n),
      .serial_data_in_i(serial_data_in), .serial_data_float_i(flt), .write_strobe_n_i(wr_n),
      .chan_sel_hi_i(a_hi), .chan_sel_lo_i(a_lo), .parallel_data_bus_i(db),
      .dac_load_strobe_n_i(ld_n), .clear_n_i(clr_n), .input_value_o(p_in),
      .dac_value_o(p_dac), .chan_power_down_o(p_pd), .hw_power_down_o(p_hw));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic chk_bank(input string nm, input qdl_bank_t e, input qdl_bank_t g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bits(input string nm, input logic [3:0] e, input logic [3:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end

   initial begin
      reset_n = 1'b0;
      {flt, a_hi, a_lo} = 3'b000;
      {wr_n, ld_n, clr_n} = 3'b111;
      db = 8'h00;
      exp_in = '0;
      step(12);
      reset_n = 1'b1;
      step(1);
      chk_bank("ser in", '0, s_in);
      chk_bank("par dac", '0, p_dac);
      chk_bits("ser pd", 4'h0, s_pd);
      chk_bits("par pd", 4'h0, p_pd);
      for (int c = 0; c < 4; c++) begin
         i_qdl_host_model.send({2'b11, c[1:0], PAT[c]}, 12);
         exp_in[c] = PAT[c];
      end
      step(4);
      chk_bank("ser in", exp_in, s_in);
      chk_bank("ser dac", '0, s_dac);
      ld_n = 1'b0;
      step(4);
      chk_bank("ser dac", exp_in, s_dac);
      i_qdl_host_model.send(12'hE3C, 12);
      exp_in[2] = 8'h3C;
      step(4);
      chk_bank("ser dac", exp_in, s_dac);
      snap = exp_in;
      ld_n = 1'b1;
      i_qdl_host_model.send(12'h777, 12);
      exp_in[3] = 8'h77;
      step(4);
      chk_bits("ser pd", 4'hF, s_pd);
      i_qdl_host_model.send(12'h966, 12);
      exp_in[1] = 8'h66;
      step(4);
      chk_bits("ser pd", 4'h2, s_pd);
      chk_bank("ser in", exp_in, s_in);
      chk_bank("ser dac", snap, s_dac);
      clr_n = 1'b0;
      step(4);
      chk_bank("ser in", '0, s_in);
      chk_bank("ser dac", '0, s_dac);
      clr_n = 1'b1;
      step(4);
      chk_bank("ser dac", '0, s_dac);
      // clocks while deselected must leave the kept word alone
      i_qdl_host_model.idle_clocks(12);
      // select pulse alone reloads what the shift register kept
      i_qdl_host_model.send(12'h000, 0);
      exp_in = 32'h0000_6600;
      step(4);
      chk_bank("ser in", exp_in, s_in);
      flt = 1'b1;
      step(4);
      chk_bits("hw pd", 4'h1, {3'b000, s_hw});
      chk_bits("par hw pd", 4'h1, {3'b000, p_hw});
      chk_bank("ser in", exp_in, s_in);
      flt = 1'b0;
      exp_in = '0;
      for (int c = 0; c < 4; c++) begin
         {a_hi, a_lo} = c[1:0];
         db = PAT[c];
         wr_n = 1'b0;
         exp_in[c] = PAT[c];
         step(4);
         chk_bank("par in", exp_in, p_in);
         wr_n = 1'b1;
         step(1);
         db = ~PAT[c];
         step(4);
         chk_bank("par in", exp_in, p_in);
      end
      chk_bank("par dac", '0, p_dac);
      ld_n = 1'b0;
      step(4);
      chk_bank("par dac", exp_in, p_dac);
      {a_hi, a_lo} = 2'b00;
      db = 8'hC3;
      wr_n = 1'b0;
      exp_in[0] = 8'hC3;
      step(4);
      chk_bank("par dac", exp_in, p_dac);
      wr_n = 1'b1;
      step(2);
      ld_n = 1'b1;
      step(4);
      snap = exp_in;
      db = 8'h99;
      wr_n = 1'b0;
      exp_in[0] = 8'h99;
      step(4);
      wr_n = 1'b1;
      step(4);
      chk_bank("par in", exp_in, p_in);
      chk_bank("par dac", snap, p_dac);
      conclude();
   end
endmodule
